// ===== cmt_map.vh
// register offsets, field positions, reset values and codes of the compare-match timer
`ifndef CMT_MAP_VH
`define CMT_MAP_VH

`define CMT_ADDR_W 16
`define CMT_ADDR_CTL 16'hFFC8
`define CMT_ADDR_CSR 16'hFFC9
`define CMT_ADDR_CONST_A 16'hFFCA
`define CMT_ADDR_CONST_B 16'hFFCB
`define CMT_ADDR_COUNT 16'hFFCC
`define CMT_ADDR_IRQ_STAT 16'hFFE0
`define CMT_ADDR_IRQ_EN 16'hFFE1
`define CMT_ADDR_IRQ_CLR 16'hFFE2

`define CMT_CTL_CKS_LSB 0
`define CMT_CTL_CKS_MSB 2
`define CMT_CTL_CCLR_LSB 3
`define CMT_CTL_CCLR_MSB 4
`define CMT_CTL_OVF_IE 5
`define CMT_CTL_MA_IE 6
`define CMT_CTL_MB_IE 7

`define CMT_CSR_OS_LSB 0
`define CMT_CSR_OS_MSB 3
`define CMT_CSR_FLAG_LSB 5

`define CMT_EV_OVF 0
`define CMT_EV_MA 1
`define CMT_EV_MB 2

`define CMT_CTL_RST 8'h00
`define CMT_OS_RST 4'h0
`define CMT_CONST_RST 8'hFF
`define CMT_COUNT_RST 8'h00
`define CMT_COUNT_MAX 8'hFF
`define CMT_FLAG_RST 3'h0
`define CMT_IRQ_EN_RST 3'h0

`define CMT_CCLR_NONE 2'h0
`define CMT_CCLR_MA 2'h1
`define CMT_CCLR_MB 2'h2
`define CMT_CCLR_EXT 2'h3

`define CMT_CKS_STOP0 3'h0
`define CMT_CKS_DIV_S 3'h1
`define CMT_CKS_DIV_M 3'h2
`define CMT_CKS_DIV_L 3'h3
`define CMT_CKS_STOP1 3'h4
`define CMT_CKS_EXT_RISE 3'h5
`define CMT_CKS_EXT_FALL 3'h6
`define CMT_CKS_EXT_BOTH 3'h7

`define CMT_DIV_W 10
`define CMT_MASK_DIV2 10'h001
`define CMT_MASK_DIV8 10'h007
`define CMT_MASK_DIV32 10'h01F
`define CMT_MASK_DIV64 10'h03F
`define CMT_MASK_DIV256 10'h0FF
`define CMT_MASK_DIV1024 10'h3FF

`define CMT_OS_KEEP 2'h0
`define CMT_OS_LOW 2'h1
`define CMT_OS_HIGH 2'h2
`define CMT_OS_TOGGLE 2'h3

`endif

// ===== cmt_sync.v
// three-stage synchroniser with agreement filter and edge pulses for one pin input
`timescale 1ns/1ps
`include "cmt_map.vh"
module cmt_sync (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire i_pin,
   output reg o_level,
   output reg o_rise,
   output reg o_fall
);
   reg s1;
   reg s2;
   reg s3;

   // s1 feeds s2 only; the filter looks at s2 and s3
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_level <= 1'b0;
         o_rise <= 1'b0;
         o_fall <= 1'b0;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         o_rise <= (s2 == s3) && s3 && !o_level;
         o_fall <= (s2 == s3) && !s3 && o_level;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule

// ===== cmt_tick.v
// count-tick generator: internal prescaler taps or filtered external clock edges
`timescale 1ns/1ps
`include "cmt_map.vh"
module cmt_tick (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [2:0] i_cks,
   input wire i_alt,
   input wire i_ext_rise,
   input wire i_ext_fall,
   output reg o_tick
);
   reg [`CMT_DIV_W-1:0] div;
   reg next_tick;

   function [`CMT_DIV_W-1:0] tap_mask;
      input [2:0] cks;
      input alt;
      begin
         case (cks)
            `CMT_CKS_DIV_S: tap_mask = alt ? `CMT_MASK_DIV2 : `CMT_MASK_DIV8;
            `CMT_CKS_DIV_M: tap_mask = alt ? `CMT_MASK_DIV32 : `CMT_MASK_DIV64;
            `CMT_CKS_DIV_L: tap_mask = alt ? `CMT_MASK_DIV256 : `CMT_MASK_DIV1024;
            default: tap_mask = `CMT_MASK_DIV1024;
         endcase
      end
   endfunction

   always @* begin
      case (i_cks)
         `CMT_CKS_DIV_S,
         `CMT_CKS_DIV_M,
         `CMT_CKS_DIV_L: next_tick = (div & tap_mask(i_cks, i_alt)) == tap_mask(i_cks, i_alt);
         `CMT_CKS_EXT_RISE: next_tick = i_ext_rise;
         `CMT_CKS_EXT_FALL: next_tick = i_ext_fall;
         `CMT_CKS_EXT_BOTH: next_tick = i_ext_rise | i_ext_fall;
         default: next_tick = 1'b0;
      endcase
   end

   // free-running divider keeps taps phase-aligned across clock-select changes
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div <= {`CMT_DIV_W{1'b0}};
         o_tick <= 1'b0;
      end else begin
         div <= div + {{(`CMT_DIV_W-1){1'b0}}, 1'b1};
         o_tick <= next_tick;
      end
   end
endmodule

// ===== cmt_top.v
// compare-match timer: counter, compares, flags, output pin and register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "cmt_map.vh"
module cmt_top (
   input wire i_clk_sys,
   input wire i_rstn,
   input wire [`CMT_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   input wire i_ext_clk,
   input wire i_ext_rst,
   input wire i_clk_sel_alt,
   output reg o_tmo,
   output reg o_tmo_oe,
   output reg o_ovf_req,
   output reg o_match_a_req,
   output reg o_match_b_req,
   output reg o_irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // reset release
   // entry is immediate; exit is retimed so no flop leaves reset near an edge

   reg [1:0] rst_pipe;
   wire rst_n;

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   ////////////////////////////////////////////////////////////////////////////////
   // state

   reg [7:0] timer_control;
   reg [3:0] output_select_bits;
   reg [2:0] flag;
   reg [2:0] armed;
   reg [7:0] constant_a;
   reg [7:0] constant_b;
   reg [7:0] running_count;
   reg [2:0] irq_stat;
   reg [2:0] irq_en;

   reg [7:0] next_rdata;
   reg next_tmo;
   reg [2:0] next_flag;
   reg [2:0] next_armed;
   reg [2:0] next_irq_stat;
   reg [7:0] next_count;

   ////////////////////////////////////////////////////////////////////////////////
   // pin inputs and count tick

   wire ext_clk_rise;
   wire ext_clk_fall;
   wire ext_rst_rise;
   wire tick;

   cmt_sync u_sync_clk (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_pin(i_ext_clk),
      .o_level(),
      .o_rise(ext_clk_rise),
      .o_fall(ext_clk_fall)
   );

   cmt_sync u_sync_rst (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_pin(i_ext_rst),
      .o_level(),
      .o_rise(ext_rst_rise),
      .o_fall()
   );

   cmt_tick u_tick (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_cks(timer_control[`CMT_CTL_CKS_MSB:`CMT_CTL_CKS_LSB]),
      .i_alt(i_clk_sel_alt),
      .i_ext_rise(ext_clk_rise),
      .i_ext_fall(ext_clk_fall),
      .o_tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // address decode

   wire wr_ctl = i_wr && (i_addr == `CMT_ADDR_CTL);
   wire wr_csr = i_wr && (i_addr == `CMT_ADDR_CSR);
   wire rd_csr = i_rd && (i_addr == `CMT_ADDR_CSR);
   wire wr_const_a = i_wr && (i_addr == `CMT_ADDR_CONST_A);
   wire wr_const_b = i_wr && (i_addr == `CMT_ADDR_CONST_B);
   wire wr_count = i_wr && (i_addr == `CMT_ADDR_COUNT);
   wire wr_irq_en = i_wr && (i_addr == `CMT_ADDR_IRQ_EN);
   wire wr_irq_clr = i_wr && (i_addr == `CMT_ADDR_IRQ_CLR);

   ////////////////////////////////////////////////////////////////////////////////
   // counter, compares and clearing

   // ticks last one cycle, so each count value is compared once
   wire [1:0] clear_mode = timer_control[`CMT_CTL_CCLR_MSB:`CMT_CTL_CCLR_LSB];
   wire clear_mode_high = clear_mode[1];
   wire clear_mode_low = clear_mode[0];
   wire match_a = tick && (running_count == constant_a);
   wire match_b = tick && (running_count == constant_b);
   wire cnt_clear;
   wire overflow;
   wire [2:0] event_vec;

   assign cnt_clear = (!clear_mode_high && clear_mode_low && match_a)
      || (clear_mode_high && !clear_mode_low && match_b)
      || (clear_mode_high && clear_mode_low && ext_rst_rise);

   // a count cleared by a match never also wraps, so no overflow then
   assign overflow = tick && (running_count == `CMT_COUNT_MAX) && !cnt_clear;

   assign event_vec = {match_b, match_a, overflow};

   // a software write to the counter wins over clearing and counting
   always @* begin
      if (wr_count) begin
         next_count = i_wdata;
      end else if (cnt_clear) begin
         next_count = `CMT_COUNT_RST;
      end else if (tick) begin
         next_count = running_count + 8'h01;
      end else begin
         next_count = running_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status flags with read-then-write-zero clearing

   // a read arms only bits that showed 1; any status write disarms all,
   // so a flag set after the read survives the following zero write
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
         wire wr_zero = wr_csr && !i_wdata[`CMT_CSR_FLAG_LSB + gi];
         wire do_clear = wr_zero && armed[gi];
         always @* begin
            // a new event in the clearing cycle keeps the flag set
            next_flag[gi] = event_vec[gi] | (flag[gi] & !do_clear);
            if (wr_csr) begin
               next_armed[gi] = 1'b0;
            end else if (rd_csr && flag[gi]) begin
               next_armed[gi] = 1'b1;
            end else begin
               next_armed[gi] = armed[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status, gated by the per-source enables

   // a status bit records only enabled events; enabling later sets no old status bit, though o_ovf_req and the match requests follow old flags
   wire [2:0] req_en;

   assign req_en[`CMT_EV_OVF] = timer_control[`CMT_CTL_OVF_IE];
   assign req_en[`CMT_EV_MA] = timer_control[`CMT_CTL_MA_IE];
   assign req_en[`CMT_EV_MB] = timer_control[`CMT_CTL_MB_IE];

   // set wins over the clear write
   always @* begin
      next_irq_stat = irq_stat;
      if (wr_irq_clr) begin
         next_irq_stat = irq_stat & ~i_wdata[2:0];
      end
      next_irq_stat = next_irq_stat | (event_vec & req_en);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output pin

   // both actions are keep while disabled, so the level holds; only the enable drops
   function out_step;
      input cur;
      input [1:0] act;
      begin
         case (act)
            `CMT_OS_KEEP: out_step = cur;
            `CMT_OS_LOW: out_step = 1'b0;
            `CMT_OS_HIGH: out_step = 1'b1;
            `CMT_OS_TOGGLE: out_step = !cur;
            default: out_step = cur;
         endcase
      end
   endfunction

   // match B acts last, so when both hit in one tick B's action applies to the level A's action left
   always @* begin
      next_tmo = o_tmo;
      if (match_a) begin
         next_tmo = out_step(next_tmo, output_select_bits[1:0]);
      end
      if (match_b) begin
         next_tmo = out_step(next_tmo, output_select_bits[3:2]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped and write-only addresses read zero
   // gating by the strobe keeps o_rdata at zero between reads

   always @* begin
      case (i_addr)
         `CMT_ADDR_CTL: next_rdata = timer_control;
         `CMT_ADDR_CSR: next_rdata = {flag, 1'b0, output_select_bits};
         `CMT_ADDR_CONST_A: next_rdata = constant_a;
         `CMT_ADDR_CONST_B: next_rdata = constant_b;
         `CMT_ADDR_COUNT: next_rdata = running_count;
         `CMT_ADDR_IRQ_STAT: next_rdata = {5'h00, irq_stat};
         `CMT_ADDR_IRQ_EN: next_rdata = {5'h00, irq_en};
         default: next_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_control <= `CMT_CTL_RST;
         output_select_bits <= `CMT_OS_RST;
         flag <= `CMT_FLAG_RST;
         armed <= `CMT_FLAG_RST;
         constant_a <= `CMT_CONST_RST;
         constant_b <= `CMT_CONST_RST;
         running_count <= `CMT_COUNT_RST;
         irq_stat <= `CMT_FLAG_RST;
         irq_en <= `CMT_IRQ_EN_RST;
      end else begin
         if (wr_ctl) begin
            timer_control <= i_wdata;
         end
         if (wr_csr) begin
            output_select_bits <= i_wdata[`CMT_CSR_OS_MSB:`CMT_CSR_OS_LSB];
         end
         if (wr_const_a) begin
            constant_a <= i_wdata;
         end
         if (wr_const_b) begin
            constant_b <= i_wdata;
         end
         if (wr_irq_en) begin
            irq_en <= i_wdata[2:0];
         end
         flag <= next_flag;
         armed <= next_armed;
         running_count <= next_count;
         irq_stat <= next_irq_stat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all from flops

   always @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 8'h00;
         o_tmo <= 1'b0;
         o_tmo_oe <= 1'b0;
         o_ovf_req <= 1'b0;
         o_match_a_req <= 1'b0;
         o_match_b_req <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         // read data valid only in the cycle after the strobe
         o_rdata <= i_rd ? next_rdata : 8'h00;
         o_tmo <= next_tmo;
         o_tmo_oe <= |output_select_bits;
         o_ovf_req <= flag[`CMT_EV_OVF] & req_en[`CMT_EV_OVF];
         o_match_a_req <= flag[`CMT_EV_MA] & req_en[`CMT_EV_MA];
         o_match_b_req <= flag[`CMT_EV_MB] & req_en[`CMT_EV_MB];
         o_irq <= |(irq_stat & irq_en);
      end
   end

endmodule

// ===== cmt_top_monitor.sv
// checker watching the compare-match timer ports
`timescale 1ns/1ps
`include "cmt_map.vh"
module cmt_top_monitor (
   input wire i_clk_sys,
   input wire i_rstn,
   input wire [`CMT_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire i_ext_clk,
   input wire i_ext_rst,
   input wire i_clk_sel_alt,
   input wire o_tmo,
   input wire o_tmo_oe,
   input wire o_ovf_req,
   input wire o_match_a_req,
   input wire o_match_b_req,
   input wire o_irq
);
   reg [7:0] ctl;
   reg [3:0] os;
   reg [2:0] ien;
   wire csr_w0 = i_wr && i_addr == `CMT_ADDR_CSR && !i_wdata[7];
   ////////////////////////////////////////////////////////////////
   // shadows of the software-written enables
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ctl <= 8'h00;
         os <= 4'h0;
         ien <= 3'h0;
      end else if (i_wr) begin
         if (i_addr == `CMT_ADDR_CTL) ctl <= i_wdata;
         if (i_addr == `CMT_ADDR_CSR) os <= i_wdata[3:0];
         if (i_addr == `CMT_ADDR_IRQ_EN) ien <= i_wdata[2:0];
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   property p_ovf_gate; o_ovf_req |-> $past(ctl[5]); endproperty
   a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request while disabled");
   property p_ma_gate; o_match_a_req |-> $past(ctl[6]); endproperty
   a_ma_gate: assert property (p_ma_gate) else $error("match A request while disabled");
   property p_mb_gate; o_match_b_req |-> $past(ctl[7]); endproperty
   a_mb_gate: assert property (p_mb_gate) else $error("match B request while disabled");
   // enable held steady, so a drop can only come from a zero write
   property p_mb_clear;
      $fell(o_match_b_req) && ctl[7] && $past(ctl[7]) |-> $past(csr_w0, 2);
   endproperty
   a_mb_clear: assert property (p_mb_clear) else $error("flag B cleared without write");
   property p_oe; o_tmo_oe == $past(|os); endproperty
   a_oe: assert property (p_oe) else $error("output enable differs from select bits");
   property p_irq; o_irq |-> $past(|ien); endproperty
   a_irq: assert property (p_irq) else $error("interrupt with no source enabled");
   property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_rd_ctl;
      $past(i_rd && i_addr == `CMT_ADDR_CTL) |-> o_rdata == $past(ctl);
   endproperty
   a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
endmodule
bind cmt_top cmt_top_monitor cmt_top_monitor_i (.i_clk_sys, .i_rstn, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_ext_clk, .i_ext_rst, .i_clk_sel_alt, .o_tmo, .o_tmo_oe,
   .o_ovf_req, .o_match_a_req, .o_match_b_req, .o_irq);

// ===== testbench.sv
// self-checking testbench of the compare-match timer
`timescale 1ns/1ps
`include "cmt_map.vh"
module testbench;
   reg i_clk_sys, i_rstn, i_wr, i_rd, i_ext_clk, i_ext_rst, i_clk_sel_alt;
   reg [15:0] i_addr;
   reg [7:0] i_wdata, v, d, lo;
   reg [2:0] en;
   reg [31:0] seed, cycles;
   integer num_errors, checked, m, i;
   wire [7:0] o_rdata;
   wire o_tmo, o_tmo_oe, o_ovf_req, o_match_a_req, o_match_b_req, o_irq;
   localparam [7:0] K = 8'h0A;
   cmt_top cmt_top_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(i_ext_clk),
      .i_ext_rst(i_ext_rst), .i_clk_sel_alt(i_clk_sel_alt), .o_tmo(o_tmo),
      .o_tmo_oe(o_tmo_oe), .o_ovf_req(o_ovf_req), .o_match_a_req(o_match_a_req),
      .o_match_b_req(o_match_b_req), .o_irq(o_irq));
   ////////////////////////////////////////////////////////////////
   function [31:0] lfsr_next(input [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string n, input [7:0] s, input [7:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("mismatch %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   // each access ends one edge after its strobe, so strobes never collide
   task wr(input [15:0] a, input [7:0] dat);
      begin
         @(posedge i_clk_sys);
         i_addr <= a;
         i_wdata <= dat;
         i_wr <= 1'b1;
         @(posedge i_clk_sys);
         i_wr <= 1'b0;
      end
   endtask
   task rd(input [15:0] a, output [7:0] r);
      begin
         @(posedge i_clk_sys);
         i_addr <= a;
         i_rd <= 1'b1;
         @(posedge i_clk_sys);
         i_rd <= 1'b0;
         #1 r = o_rdata;
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", checked, num_errors);
         if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
         end else begin
            $display("Some tests failed");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   // pin clock at an eighth of the system rate, slow enough to pass the filter
   always @(posedge i_clk_sys) begin
      if (cycles[1:0] == 2'h3) begin
         i_ext_clk <= ~i_ext_clk;
      end
      cycles <= cycles + 1;
      if (cycles == 32'd5000) begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
   initial begin
      {i_rstn, i_wr, i_rd, i_ext_clk, i_ext_rst} = 5'h00;
      i_clk_sel_alt = 1'b1;
      i_addr = 16'h0000;
      i_wdata = 8'h00;
      cycles = 0;
      num_errors = 0;
      checked = 0;
      seed = 32'hFCD83D51;
      repeat (6) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      rd(`CMT_ADDR_CTL, v); chk("ctl reset", v, 8'h00);
      rd(`CMT_ADDR_CSR, v); chk("csr reset", v, 8'h00);
      rd(`CMT_ADDR_CONST_B, v); chk("const b reset", v, 8'hFF);
      wr(16'hFFC0, 8'h5A);
      rd(16'hFFC0, v); chk("unmapped", v, 8'h00);
      // control fields with the clock select kept stopped
      for (i = 0; i < 4; i = i + 1) begin
         seed = lfsr_next(seed);
         wr(`CMT_ADDR_CTL, seed[7:0] & 8'hF8);
         rd(`CMT_ADDR_CTL, v); chk("ctl rw", v, seed[7:0] & 8'hF8);
      end
      for (i = 0; i < 4; i = i + 1) begin
         seed = lfsr_next(seed);
         d = (i == 0 || i == 3) ? 8'h00 : {4'h0, seed[3:0]};
         wr(`CMT_ADDR_CSR, d);
         repeat (2) @(posedge i_clk_sys);
         chk("tmo oe", o_tmo_oe, |d);
      end
      wr(`CMT_ADDR_IRQ_EN, 8'h07);
      for (m = 0; m < 4; m = m + 1) begin
         seed = lfsr_next(seed);
         en = seed[2:0];
         wr(`CMT_ADDR_CONST_A, K);
         wr(`CMT_ADDR_CONST_B, K + 8'h02);
         wr(`CMT_ADDR_COUNT, 8'hFE);
         // match A drives the pin high, match B drives it low
         wr(`CMT_ADDR_CSR, 8'h06);
         wr(`CMT_ADDR_CTL, {en, m[1:0], 3'b001});
         repeat (40) @(posedge i_clk_sys);
         i_ext_rst <= (m == 3);
         repeat (10) @(posedge i_clk_sys);
         wr(`CMT_ADDR_CTL, {en, m[1:0], 3'b000});
         repeat (3) @(posedge i_clk_sys);
         chk("ovf req", o_ovf_req, en[0]);
         chk("ma req", o_match_a_req, en[1]);
         chk("mb req", o_match_b_req, en[2] && m != 1);
         chk("irq", o_irq, |(en & {m != 1, 2'b11}));
         // with clearing on match B the last action depends on the tick phase
         if (m != 2) begin
            chk("tmo", o_tmo, m == 1);
         end
         rd(`CMT_ADDR_COUNT, v); chk("count cleared", v <= K + 8'h02, m != 0);
         rd(`CMT_ADDR_IRQ_STAT, v); chk("irq stat", v, {5'h00, en & {m != 1, 2'b11}});
         wr(`CMT_ADDR_IRQ_EN, 8'h00);
         repeat (2) @(posedge i_clk_sys);
         chk("irq masked", o_irq, 1'b0);
         wr(`CMT_ADDR_IRQ_EN, 8'h07);
         wr(`CMT_ADDR_CSR, 8'h00);
         wr(`CMT_ADDR_CSR, 8'hE0);
         rd(`CMT_ADDR_CSR, v); chk("flags", v, {m != 1, 7'h60});
         wr(`CMT_ADDR_CSR, 8'hE0);
         wr(`CMT_ADDR_CSR, 8'h00);
         rd(`CMT_ADDR_CSR, v); chk("flags kept", v, {m != 1, 7'h60});
         wr(`CMT_ADDR_CSR, 8'h00);
         rd(`CMT_ADDR_CSR, v); chk("flags cleared", v, 8'h00);
         wr(`CMT_ADDR_IRQ_CLR, 8'h07);
         repeat (2) @(posedge i_clk_sys);
         chk("irq cleared", o_irq, 1'b0);
         i_ext_rst <= 1'b0;
      end
      // external pin as count clock: both edges, then rising only, then falling only
      // 66 counting cycles hold 16 or 17 edges four cycles apart, or 8 or 9 eight apart
      for (i = 0; i < 3; i = i + 1) begin
         d = (i == 0) ? 8'h07 : 8'h04 + i[7:0];
         lo = (i == 0) ? 8'h10 : 8'h08;
         wr(`CMT_ADDR_COUNT, 8'h00);
         wr(`CMT_ADDR_CTL, d);
         repeat (64) @(posedge i_clk_sys);
         wr(`CMT_ADDR_CTL, 8'h00);
         rd(`CMT_ADDR_COUNT, v);
         chk("ext count", v >= lo && v <= lo + 8'h01, 1'b1);
      end
      finish_test;
   end
endmodule
